/* rtl/tmr_regs.svh */
// Register offsets, bit positions, reset values and counter constants
// Assumes inclusion by bare name from rtl/ on the include path
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH

// ----------------------------------------------------------------------
// Special-function register addresses
// ----------------------------------------------------------------------
`define TMR_ADDR_CTRL       8'h88
`define TMR_ADDR_T0_LOW     8'h8a
`define TMR_ADDR_T1_LOW     8'h8b
`define TMR_ADDR_T0_HIGH    8'h8c
`define TMR_ADDR_T1_HIGH    8'h8d

// ----------------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------------
`define TMR_BIT_T1_OVF      3'h7
`define TMR_BIT_T1_RUN      3'h6
`define TMR_BIT_T0_OVF      3'h5
`define TMR_BIT_T0_RUN      3'h4
`define TMR_BIT_X1_REQ      3'h3
`define TMR_BIT_X1_TRIG     3'h2
`define TMR_BIT_X0_REQ      3'h1
`define TMR_BIT_X0_TRIG     3'h0

// ----------------------------------------------------------------------
// Reset values and counter constants
// ----------------------------------------------------------------------
`define TMR_CTRL_RESET      8'h00
`define TMR_CNT_RESET       8'h00
`define TMR_CNT_MAX         8'hff
`define TMR_CNT_INC         8'h01
`define TMR_RDATA_IDLE      8'h00
`define TMR_BIT_SEL_W       3
`define TMR_BIT_BASE_MSB    7

`endif

/* rtl/tmr_pkg.sv */
// Shared types for the timer and external interrupt control block
// Assumes compilation before any module that names tmr_pkg
package tmr_pkg;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef logic [7:0] tmr_byte_t;

  // Trigger selection of an external interrupt pin
  typedef enum logic {
    TMR_TRIG_LEVEL,
    TMR_TRIG_EDGE
  } tmr_trig_t;

endpackage : tmr_pkg

/* rtl/tmr_ext_irq.sv */
// One external interrupt input: synchroniser, edge detect, request flag
// Assumes an asynchronous active-low pin and core-clock control strobes
`timescale 1ns/1ps

module tmr_ext_irq (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pin_n,
  input  wire logic trig_edge,
  input  wire logic vec_ack,
  input  wire logic sw_wr_en,
  input  wire logic sw_wr_val,
  output logic      req_flag
);

  logic             sync1_reg;
  logic             sync2_reg;
  logic             prev_reg;
  logic             req_next;
  logic             fall_seen;
  tmr_pkg::tmr_trig_t trig_mode;

  // ----------------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------------
  // Two-stage synchroniser plus one history stage, idle high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg  <= 1'b1;
    end else begin
      sync1_reg <= pin_n;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Request flag
  // ----------------------------------------------------------------------
  // High sample followed by low sample
  assign fall_seen = prev_reg & ~sync2_reg;
  assign trig_mode = trig_edge ? tmr_pkg::TMR_TRIG_EDGE : tmr_pkg::TMR_TRIG_LEVEL;

  // Level mode tracks the pin; edge mode is sticky, set beats clear
  always_comb begin
    unique case (trig_mode)
      tmr_pkg::TMR_TRIG_LEVEL: req_next = ~sync2_reg;
      tmr_pkg::TMR_TRIG_EDGE: begin
        if (fall_seen) begin
          req_next = 1'b1;
        end else if (sw_wr_en) begin
          req_next = sw_wr_val;
        end else if (vec_ack) begin
          req_next = 1'b0;
        end else begin
          req_next = req_flag;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_flag <= 1'b0;
    end else begin
      req_flag <= req_next;
    end
  end

endmodule : tmr_ext_irq

/* rtl/tmr_top.sv */
// Timer 0/1 count registers, shared control register, external irq flags
// Assumes a core-clock SFR bus with one-cycle strobes and same-clock acks
//
// What this block does
// - Each timer has two count bytes, separate or joined as sixteen bits.
// - Timer 0 high byte sits at 8CH, low byte at 8AH.
// - Timer 1 high byte sits at 8DH, low byte at 8BH.
// - Control bit 7 sets whenever timer 1 overflows.
// - Control bit 7 clears when the core vectors to timer 1 service.
// - Timer 1 counts while control bit 6 is one.
// - Control bit 5 sets on timer 0 overflow, clears on its vectoring.
// - Timer 0 counts while control bit 4 is one.
// - Bit 3 sets on falling edge or low level of pin 1.
// - Vectoring clears an external request only in edge mode.
// - Bit 2 one selects falling edge for pin 1, zero low level.
// - Bit 1 sets on falling edge or low level of pin 0.
// - Bit 0 one selects falling edge for pin 0, zero low level.
// - Lower four control bits never affect either timer.
// - Control register at 88H, bit addressable, resets to 00H.
`timescale 1ns/1ps
`include "tmr_regs.svh"

module tmr_top #(
  parameter int NUM_TIMERS = 2
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic [7:0]             sfr_addr,
  input  wire logic                   sfr_wr,
  input  wire logic [7:0]             sfr_wdata,
  input  wire logic                   sfr_rd,
  input  wire logic [7:0]             sfr_bit_addr,
  input  wire logic                   sfr_bit_wr,
  input  wire logic                   sfr_bit_val,
  input  wire logic [NUM_TIMERS-1:0]  count_tick,
  input  wire logic [NUM_TIMERS-1:0]  mode_16bit,
  input  wire logic [NUM_TIMERS-1:0]  vec_ack_timer,
  input  wire logic                   vec_ack_ext0,
  input  wire logic                   vec_ack_ext1,
  input  wire logic                   ext_irq_pin_0_n,
  input  wire logic                   ext_irq_pin_1_n,
  output logic [7:0]                  sfr_rdata,
  output logic                        sfr_rd_hit,
  output logic                        timer0_overflow_flag,
  output logic                        timer1_overflow_flag,
  output logic                        ext_irq0_request_flag,
  output logic                        ext_irq1_request_flag
);

  // ----------------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------------
  // Byte address match, used for every register
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
    addr_is = (addr == target);
  endfunction : addr_is

  // Low byte address of a timer
  function automatic logic [7:0] low_addr(input int idx);
    low_addr = (idx == 0) ? `TMR_ADDR_T0_LOW : `TMR_ADDR_T1_LOW;
  endfunction : low_addr

  // High byte address of a timer
  function automatic logic [7:0] high_addr(input int idx);
    high_addr = (idx == 0) ? `TMR_ADDR_T0_HIGH : `TMR_ADDR_T1_HIGH;
  endfunction : high_addr

  // Overflow flag position of a timer
  function automatic logic [2:0] ovf_bit(input int idx);
    ovf_bit = (idx == 0) ? `TMR_BIT_T0_OVF : `TMR_BIT_T1_OVF;
  endfunction : ovf_bit

  // Run control position of a timer
  function automatic logic [2:0] run_bit(input int idx);
    run_bit = (idx == 0) ? `TMR_BIT_T0_RUN : `TMR_BIT_T1_RUN;
  endfunction : run_bit

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  tmr_pkg::tmr_byte_t          cnt_low_reg  [NUM_TIMERS];
  tmr_pkg::tmr_byte_t          cnt_high_reg [NUM_TIMERS];
  logic [NUM_TIMERS-1:0]       ovf_reg;
  logic [NUM_TIMERS-1:0]       run_reg;
  logic                        trig0_reg;
  logic                        trig1_reg;
  logic                        x0_req;
  logic                        x1_req;
  tmr_pkg::tmr_byte_t          ctrl_view;
  tmr_pkg::tmr_byte_t          rdata_next;
  logic                        rd_hit_next;
  logic                        ctrl_byte_wr;
  logic                        ctrl_bit_hit;
  logic [7:0]                  ctrl_wr_en;
  logic [7:0]                  ctrl_wr_val;
  logic [7:0]                  bit_onehot;
  logic [NUM_TIMERS-1:0]       low_sel;
  logic [NUM_TIMERS-1:0]       high_sel;
  tmr_pkg::tmr_byte_t          timer_rd [NUM_TIMERS];

  // ----------------------------------------------------------------------
  // Control register write strobes
  // ----------------------------------------------------------------------
  // Byte write or single-bit write, both land in the same flops
  assign ctrl_byte_wr = sfr_wr & addr_is(sfr_addr, `TMR_ADDR_CTRL);
  assign ctrl_bit_hit = sfr_bit_wr &
                        (sfr_bit_addr[`TMR_BIT_BASE_MSB:`TMR_BIT_SEL_W] ==
                         5'(`TMR_ADDR_CTRL >> `TMR_BIT_SEL_W));
  assign bit_onehot   = 8'h01 << sfr_bit_addr[`TMR_BIT_SEL_W-1:0];
  assign ctrl_wr_en   = ctrl_byte_wr ? 8'hff : (ctrl_bit_hit ? bit_onehot : 8'h00);
  assign ctrl_wr_val  = ctrl_byte_wr ? sfr_wdata : {8{sfr_bit_val}};

  // ----------------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_timer
      logic               tick;
      logic               low_wrap;
      logic               high_wrap;
      logic               overflow;
      logic               low_wr;
      logic               high_wr;
      logic               ovf_next;
      logic               run_next;
      tmr_pkg::tmr_byte_t low_next;
      tmr_pkg::tmr_byte_t high_next;

      // Counting gated only by this timer's run bit
      assign tick      = run_reg[gi] & count_tick[gi];
      // Wrap from maximum to zero
      assign low_wrap  = tick & (cnt_low_reg[gi] == `TMR_CNT_MAX);
      assign high_wrap = low_wrap & (cnt_high_reg[gi] == `TMR_CNT_MAX);
      // Joined mode overflows on the full sixteen-bit wrap
      assign overflow  = mode_16bit[gi] ? high_wrap : low_wrap;

      assign low_sel[gi]  = addr_is(sfr_addr, low_addr(gi));
      assign high_sel[gi] = addr_is(sfr_addr, high_addr(gi));
      assign low_wr       = sfr_wr & low_sel[gi];
      assign high_wr      = sfr_wr & high_sel[gi];
      assign timer_rd[gi] = high_sel[gi] ? cnt_high_reg[gi] : cnt_low_reg[gi];

      // Software write beats a count in the same cycle
      assign low_next  = low_wr ? sfr_wdata :
                         (tick ? cnt_low_reg[gi] + `TMR_CNT_INC : cnt_low_reg[gi]);
      // High byte carries only in joined mode
      assign high_next = high_wr ? sfr_wdata :
                         ((mode_16bit[gi] & low_wrap) ?
                          cnt_high_reg[gi] + `TMR_CNT_INC : cnt_high_reg[gi]);

      // Overflow set beats software or vector clear
      assign ovf_next  = overflow ? 1'b1 :
                         (ctrl_wr_en[ovf_bit(gi)] ? ctrl_wr_val[ovf_bit(gi)] :
                          (vec_ack_timer[gi] ? 1'b0 : ovf_reg[gi]));
      assign run_next  = ctrl_wr_en[run_bit(gi)] ? ctrl_wr_val[run_bit(gi)] :
                         run_reg[gi];

      // Count bytes
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          cnt_low_reg[gi]  <= `TMR_CNT_RESET;
          cnt_high_reg[gi] <= `TMR_CNT_RESET;
        end else begin
          cnt_low_reg[gi]  <= low_next;
          cnt_high_reg[gi] <= high_next;
        end
      end

      // Flag raised on the edge that wraps the counter
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          ovf_reg[gi] <= 1'(`TMR_CTRL_RESET >> ovf_bit(gi));
          run_reg[gi] <= 1'(`TMR_CTRL_RESET >> run_bit(gi));
        end else begin
          ovf_reg[gi] <= ovf_next;
          run_reg[gi] <= run_next;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // External interrupt trigger selection
  // ----------------------------------------------------------------------
  // Software-owned trigger bits in the low nibble
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trig0_reg <= 1'(`TMR_CTRL_RESET >> `TMR_BIT_X0_TRIG);
      trig1_reg <= 1'(`TMR_CTRL_RESET >> `TMR_BIT_X1_TRIG);
    end else begin
      if (ctrl_wr_en[`TMR_BIT_X0_TRIG]) begin
        trig0_reg <= ctrl_wr_val[`TMR_BIT_X0_TRIG];
      end
      if (ctrl_wr_en[`TMR_BIT_X1_TRIG]) begin
        trig1_reg <= ctrl_wr_val[`TMR_BIT_X1_TRIG];
      end
    end
  end

  // ----------------------------------------------------------------------
  // External interrupt request flags
  // ----------------------------------------------------------------------
  // Pin 0 request
  tmr_ext_irq u_ext0 (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pin_n     (ext_irq_pin_0_n),
    .trig_edge (trig0_reg),
    .vec_ack   (vec_ack_ext0),
    .sw_wr_en  (ctrl_wr_en[`TMR_BIT_X0_REQ]),
    .sw_wr_val (ctrl_wr_val[`TMR_BIT_X0_REQ]),
    .req_flag  (x0_req)
  );

  // Pin 1 request
  tmr_ext_irq u_ext1 (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pin_n     (ext_irq_pin_1_n),
    .trig_edge (trig1_reg),
    .vec_ack   (vec_ack_ext1),
    .sw_wr_en  (ctrl_wr_en[`TMR_BIT_X1_REQ]),
    .sw_wr_val (ctrl_wr_val[`TMR_BIT_X1_REQ]),
    .req_flag  (x1_req)
  );

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Assembled control byte
  assign ctrl_view = {ovf_reg[1], run_reg[1], ovf_reg[0], run_reg[0],
                      x1_req, trig1_reg, x0_req, trig0_reg};

  // Read mux; unmapped addresses answer zero with no hit
  assign rd_hit_next = addr_is(sfr_addr, `TMR_ADDR_CTRL) | (|low_sel) | (|high_sel);
  assign rdata_next  = addr_is(sfr_addr, `TMR_ADDR_CTRL) ? ctrl_view :
                       ((low_sel[1] | high_sel[1]) ? timer_rd[1] :
                        ((low_sel[0] | high_sel[0]) ? timer_rd[0] : `TMR_RDATA_IDLE));

  // Read data registered one cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sfr_rdata  <= `TMR_RDATA_IDLE;
      sfr_rd_hit <= 1'b0;
    end else begin
      sfr_rdata  <= sfr_rd ? rdata_next : `TMR_RDATA_IDLE;
      sfr_rd_hit <= sfr_rd & rd_hit_next;
    end
  end

  // ----------------------------------------------------------------------
  // Flag outputs
  // ----------------------------------------------------------------------
  // Straight from the flag flops
  assign timer0_overflow_flag  = ovf_reg[0];
  assign timer1_overflow_flag  = ovf_reg[1];
  assign ext_irq0_request_flag = x0_req;
  assign ext_irq1_request_flag = x1_req;

endmodule : tmr_top

/* tb/tmr_pin_src.sv */
// Outside interrupt sources on the two active-low request pins
// Assumes the bench moves hold_low just after a clock edge
`timescale 1ns/1ps

module tmr_pin_src (
  input  wire logic [1:0] hold_low,
  output logic      [1:0] pin_n
);
  // Released pins rest high on pull-ups; a source holds low while asking
  assign pin_n = ~hold_low;
endmodule : tmr_pin_src

/* tb/tmr_top_chk.sv */
// Port-level checks for the timer and external irq block
// Assumes a bind onto tmr_top; sees its ports only
`timescale 1ns/1ps
`include "tmr_regs.svh"

module tmr_top_chk #(
  parameter int NUM_TIMERS = 2
) (
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire logic [7:0]            sfr_addr,
  input wire logic                  sfr_wr,
  input wire logic                  sfr_rd,
  input wire logic                  sfr_bit_wr,
  input wire logic [NUM_TIMERS-1:0] count_tick,
  input wire logic [NUM_TIMERS-1:0] vec_ack_timer,
  input wire logic                  ext_irq_pin_0_n,
  input wire logic                  ext_irq_pin_1_n,
  input wire logic [7:0]            sfr_rdata,
  input wire logic                  sfr_rd_hit,
  input wire logic                  timer0_overflow_flag,
  input wire logic                  timer1_overflow_flag,
  input wire logic                  ext_irq0_request_flag,
  input wire logic                  ext_irq1_request_flag
);
  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  wire logic mapped = (sfr_addr == `TMR_ADDR_CTRL) || (sfr_addr >= `TMR_ADDR_T0_LOW
                      && sfr_addr <= `TMR_ADDR_T1_HIGH);
  wire logic no_wr  = !sfr_wr && !sfr_bit_wr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence t0_ack_s; vec_ack_timer[0] && !count_tick[0] && no_wr; endsequence
  sequence t1_ack_s; vec_ack_timer[1] && !count_tick[1] && no_wr; endsequence

  mapped_hit_a: assert property (sfr_rd && mapped |=> sfr_rd_hit)
    else $error("mapped read gave no hit");
  unmapped_rd_a: assert property (sfr_rd && !mapped
    |=> !sfr_rd_hit && sfr_rdata == 8'h00) else $error("unmapped read answered");
  rd_idle_a: assert property (!sfr_rd |=> !sfr_rd_hit && sfr_rdata == `TMR_RDATA_IDLE)
    else $error("read data stood too long");
  t0_ack_clr_a: assert property (t0_ack_s |=> !timer0_overflow_flag)
    else $error("timer 0 flag kept after ack");
  t1_ack_clr_a: assert property (t1_ack_s |=> !timer1_overflow_flag)
    else $error("timer 1 flag kept after ack");
  t1_hold_a: assert property (timer1_overflow_flag && !vec_ack_timer[1] && no_wr
    |=> timer1_overflow_flag) else $error("timer 1 flag lost");
  t0_rise_a: assert property ($rose(timer0_overflow_flag)
    |-> $past(count_tick[0] || sfr_wr || sfr_bit_wr)) else $error("timer 0 flag no cause");
  x0_rise_a: assert property ($rose(ext_irq0_request_flag) && $past(no_wr)
    |-> !$past(ext_irq_pin_0_n, 2) || !$past(ext_irq_pin_0_n, 3) || !$past(ext_irq_pin_0_n, 4))
    else $error("irq 0 flag without low pin");
  x1_rise_a: assert property ($rose(ext_irq1_request_flag) && $past(no_wr)
    |-> !$past(ext_irq_pin_1_n, 2) || !$past(ext_irq_pin_1_n, 3) || !$past(ext_irq_pin_1_n, 4))
    else $error("irq 1 flag without low pin");
endmodule : tmr_top_chk

/* tb/tmr_top_tb_top.sv */
// Self-checking bench for the timer and external irq block
// Assumes rtl/ on the include path; checker bound at the foot
`timescale 1ns/1ps
`include "tmr_regs.svh"

module tmr_top_tb_top;
  logic       clk = 1'b0, sys_rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic       sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0, vec_ack_ext0 = 1'b0, vec_ack_ext1 = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_bit_addr = 8'h00, sfr_rdata;
  logic [1:0] count_tick = 2'h0, mode_16bit = 2'h0, vec_ack_timer = 2'h0, low_req = 2'h0;
  logic [1:0] pin_n;
  logic       sfr_rd_hit, t0f, t1f, x0f, x1f;
  wire  [3:0] flags = {t1f, t0f, x1f, x0f};
  int         fails = 0, comparisons = 0;

  always #5 clk = ~clk;

  tmr_top i_tmr_top (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_bit_addr(sfr_bit_addr), .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_val(sfr_bit_val), .count_tick(count_tick), .mode_16bit(mode_16bit),
    .vec_ack_timer(vec_ack_timer), .vec_ack_ext0(vec_ack_ext0), .vec_ack_ext1(vec_ack_ext1),
    .ext_irq_pin_0_n(pin_n[0]), .ext_irq_pin_1_n(pin_n[1]), .sfr_rdata(sfr_rdata),
    .sfr_rd_hit(sfr_rd_hit), .timer0_overflow_flag(t0f), .timer1_overflow_flag(t1f),
    .ext_irq0_request_flag(x0f), .ext_irq1_request_flag(x1f));
  tmr_pin_src i_tmr_pin_src (.hold_low(low_req), .pin_n(pin_n));

  // ------------------------------------------------------------
  // Bus and check helpers
  // ------------------------------------------------------------
  task automatic complete_run;
    $display("counts: comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1 {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
    @(posedge clk) #1 sfr_wr = 1'b0;
  endtask : wr
  task automatic bwr(input logic [7:0] a, input logic v);
    @(posedge clk) #1 {sfr_bit_addr, sfr_bit_val, sfr_bit_wr} = {a, v, 1'b1};
    @(posedge clk) #1 sfr_bit_wr = 1'b0;
  endtask : bwr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    @(posedge clk) #1 {sfr_addr, sfr_rd} = {a, 1'b1};
    @(posedge clk) #1 sfr_rd = 1'b0;
    chk(sfr_rdata, exp, "read data");
    chk({7'h0, sfr_rd_hit}, {7'h0, hit}, "read hit");
  endtask : rd
  task automatic ack(input logic [3:0] w);
    @(posedge clk) #1 {vec_ack_ext1, vec_ack_ext0, vec_ack_timer} = w;
    @(posedge clk) #1 {vec_ack_ext1, vec_ack_ext0, vec_ack_timer} = 4'h0;
  endtask : ack
  task automatic tick(input logic [1:0] m, input int n);
    @(posedge clk) #1 count_tick = m;
    repeat (n) @(posedge clk);
    #1 count_tick = 2'h0;
  endtask : tick
  task automatic wait_flag(input int i, input logic v);
    int k;
    k = 0;
    while (flags[i] !== v && k < 10) begin
      @(posedge clk) #1 k++;
    end
    chk({7'h0, flags[i]}, {7'h0, v}, "flag level");
    if (k == 10) complete_run();
  endtask : wait_flag

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 5; i++) rd((i == 0) ? 8'h88 : 8'h89 + 8'(i), 8'h00, 1'b1);
    rd(8'h8e, 8'h00, 1'b0);
    rd(8'h89, 8'h00, 1'b0);
    $display("done: reset values");
  endtask : t_reset
  task automatic t_map;
    for (int i = 0; i < 4; i++) wr(8'h8a + 8'(i), 8'h11 * 8'(i + 1));
    for (int i = 0; i < 4; i++) rd(8'h8a + 8'(i), 8'h11 * 8'(i + 1), 1'b1);
    $display("done: address map");
  endtask : t_map
  task automatic t_t0_wide;
    mode_16bit = 2'b01;
    wr(8'h8a, 8'hfe);
    wr(8'h8c, 8'hff);
    bwr(8'h8c, 1'b1);
    tick(2'b01, 1);
    chk({7'h0, t0f}, 8'h00, "t0 early flag");
    tick(2'b01, 1);
    chk({7'h0, t0f}, 8'h01, "t0 wrap flag");
    rd(8'h8a, 8'h00, 1'b1);
    rd(8'h8c, 8'h00, 1'b1);
    rd(8'h88, 8'h30, 1'b1);
    ack(4'b0001);
    rd(8'h88, 8'h10, 1'b1);
    bwr(8'h8c, 1'b0);
    $display("done: timer 0 wide wrap");
  endtask : t_t0_wide
  task automatic t_t1_byte;
    wr(8'h8b, 8'hff);
    wr(8'h8d, 8'h55);
    wr(8'h88, 8'h40);
    tick(2'b10, 1);
    chk({7'h0, t1f}, 8'h01, "t1 wrap flag");
    rd(8'h8b, 8'h00, 1'b1);
    rd(8'h8d, 8'h55, 1'b1);
    ack(4'b0010);
    chk({7'h0, t1f}, 8'h00, "t1 ack");
    bwr(8'h8e, 1'b0);
    tick(2'b10, 3);
    rd(8'h8b, 8'h00, 1'b1);
    $display("done: timer 1 byte wrap");
  endtask : t_t1_byte
  task automatic t_mix;
    mode_16bit = 2'b10;
    wr(8'h8a, 8'hff);
    wr(8'h8c, 8'h12);
    wr(8'h8b, 8'hff);
    wr(8'h8d, 8'hff);
    wr(8'h88, 8'h50);
    tick(2'b11, 1);
    chk({6'h0, t1f, t0f}, 8'h03, "both wrap flags");
    rd(8'h8c, 8'h12, 1'b1);
    rd(8'h8d, 8'h00, 1'b1);
    bwr(8'h8f, 1'b0);
    bwr(8'h8d, 1'b0);
    rd(8'h88, 8'h50, 1'b1);
    $display("done: mixed widths");
  endtask : t_mix
  task automatic t_nibble;
    wr(8'h88, 8'h0f);
    wr(8'h88, 8'h0f); // Second write lands in edge mode
    tick(2'b11, 3);
    rd(8'h8a, 8'h00, 1'b1);
    rd(8'h8b, 8'h00, 1'b1);
    rd(8'h88, 8'h0f, 1'b1);
    ack(4'b1100);
    rd(8'h88, 8'h05, 1'b1);
    $display("done: low nibble");
  endtask : t_nibble
  task automatic t_edge;
    for (int j = 0; j < 2; j++) begin
      @(posedge clk) #1 low_req = 2'b01 << j;
      repeat (3) @(posedge clk);
      #1 low_req = 2'h0;
      wait_flag(j, 1'b1);
      repeat (4) @(posedge clk);
      chk({7'h0, flags[j]}, 8'h01, "edge latched");
      ack(4'b0100 << j);
      chk({7'h0, flags[j]}, 8'h00, "edge ack");
    end
    $display("done: edge mode");
  endtask : t_edge
  task automatic t_level;
    wr(8'h88, 8'h00);
    for (int j = 0; j < 2; j++) begin
      @(posedge clk) #1 low_req = 2'b01 << j;
      wait_flag(j, 1'b1);
      ack(4'b0100 << j);
      chk({7'h0, flags[j]}, 8'h01, "level ack");
      @(posedge clk) #1 low_req = 2'h0;
      wait_flag(j, 1'b0);
    end
    $display("done: level mode");
  endtask : t_level

  initial begin
    repeat (3) @(posedge clk);
    #1 sys_rst = 1'b0;
    t_reset();
    t_map();
    t_t0_wide();
    t_t1_byte();
    t_mix();
    t_nibble();
    t_edge();
    t_level();
    complete_run();
  end
endmodule : tmr_top_tb_top

bind tmr_top tmr_top_chk #(.NUM_TIMERS(NUM_TIMERS)) i_tmr_top_chk (.clk(clk),
  .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_bit_wr(sfr_bit_wr), .count_tick(count_tick), .vec_ack_timer(vec_ack_timer),
  .ext_irq_pin_0_n(ext_irq_pin_0_n), .ext_irq_pin_1_n(ext_irq_pin_1_n),
  .sfr_rdata(sfr_rdata), .sfr_rd_hit(sfr_rd_hit),
  .timer0_overflow_flag(timer0_overflow_flag), .timer1_overflow_flag(timer1_overflow_flag),
  .ext_irq0_request_flag(ext_irq0_request_flag),
  .ext_irq1_request_flag(ext_irq1_request_flag));
